/* rtl/dbcd_decoder.v */
// Command decoder and sequencer for a disc controller
//
// Overview of operation
// - Hold secondary until prior command done
// - Pair first starts nothing long
// - Poll off once secondary accepted
// - Poll withdrawn within fifty microseconds
// - Unsupported legacy commands give error
// - Decode only lower five opcode bits
// - Listen 08 and 09 opcode decode
// - Listen 0A 0B 0C decode
// - Opcode-free listen and talk decode
// - Clears and identify via own sequences
// - Cylinder high byte first
// - Sector count high byte first
// - Broken pair flags program error
// - Poll off until selftest and drive ready
`default_nettype none
`include "dbcd_regs.vh"
module dbcd_decoder (
   input  wire        clk_in,
   input  wire        reset_in,
   input  wire [7:0]  bus_data_in,
   input  wire        bus_atn_in,
   input  wire        bus_dav_in,
   input  wire        listen_in,
   input  wire        talk_in,
   input  wire        univ_clear_in,
   input  wire        sel_clear_in,
   input  wire        identify_in,
   input  wire        selftest_ok_in,
   input  wire        drive_ready_in,
   input  wire        cmd_done_in,
   output reg         byte_accept_out,
   output reg         poll_enable_out,
   output reg         cmd_valid_out,
   output reg  [4:0]  cmd_code_out,
   output reg         long_op_ok_out,
   output reg  [1:0]  error_out,
   output reg         error_valid_out,
   output reg  [7:0]  unit_out,
   output reg  [15:0] cylinder_out,
   output reg  [7:0]  head_out,
   output reg  [7:0]  sector_out,
   output reg  [15:0] sector_count_out,
   output reg         params_valid_out
);
   localparam [31:0] PPD_CYC = `DBCD_PPD_NS / `DBCD_CLK_NS;
   localparam [2:0] ST_POWER = 3'h0;
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_OPC   = 3'h2;
   localparam [2:0] ST_PARAM = 3'h3;
   localparam [2:0] ST_BUSY  = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire [14:0] sync_q;
   dbcd_sync #(.W(15)) u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     ({bus_data_in, bus_atn_in, bus_dav_in, listen_in, talk_in,
                  univ_clear_in, sel_clear_in, identify_in}),
      .q_out    (sync_q)
   );
   wire [7:0] s_data  = sync_q[14:7];
   wire       s_atn   = sync_q[6];
   wire       s_dav   = sync_q[5];
   wire       s_lsn   = sync_q[4];
   wire       s_tlk   = sync_q[3];
   wire       s_uclr  = sync_q[2];
   wire       s_sclr  = sync_q[1];
   wire       s_ident = sync_q[0];

   reg        dav_q;
   reg  [2:0] state;
   reg  [4:0] sec;
   reg  [2:0] pidx;
   reg  [2:0] plen;
   reg  [1:0] pend_pair;
   reg  [4:0] pend_code;
   reg        ppd_wait;
   reg [15:0] ppd_cnt;
   reg  [7:0] hi_byte;
   wire       dav_rise = s_dav & ~dav_q;
   wire       is_sec   = s_atn & (s_data[6:5] == 2'b11);
   wire [4:0] opc      = s_data[4:0];

   // Decode of secondary plus opcode
   reg  [4:0] dec_code;
   reg  [1:0] dec_pair;
   reg  [2:0] dec_len;
   always @* begin
      dec_code = `DBCD_C_NONE;
      dec_pair = `DBCD_P_NONE;
      dec_len  = 3'h1;
      case (sec)
         `DBCD_SEC_CMD8: begin
            case (opc)
               `DBCD_OP_SEEK:    begin dec_code = `DBCD_C_SEEK; dec_len = 3'h5; end
               `DBCD_OP_STATUS:  begin dec_code = `DBCD_C_REQ_STATUS; dec_pair = `DBCD_P_ADDR; end
               `DBCD_OP_READ:    begin dec_code = `DBCD_C_UBUF_READ; dec_pair = `DBCD_P_TX; end
               `DBCD_OP_VERIFY:  begin dec_code = `DBCD_C_VERIFY; dec_len = 3'h3; end
               `DBCD_OP_WRITE:   begin dec_code = `DBCD_C_UBUF_WRITE; dec_pair = `DBCD_P_RX; end
               `DBCD_OP_INIT:    begin dec_code = `DBCD_C_INIT; dec_pair = `DBCD_P_RX; end
               `DBCD_OP_SETADDR: begin dec_code = `DBCD_C_SET_ADDR; dec_len = 3'h5; end
               `DBCD_OP_LOGADDR: begin dec_code = `DBCD_C_REQ_LOG; dec_pair = `DBCD_P_ADDR; end
               `DBCD_OP_END:     dec_code = `DBCD_C_END;
               default:          dec_code = `DBCD_C_NONE;
            endcase
         end
         `DBCD_SEC_CMD9: begin
            if (opc == `DBCD_OP_WRITE) begin
               dec_code = `DBCD_C_BUF_WRITE;
               dec_pair = `DBCD_P_RX;
            end
         end
         `DBCD_SEC_CMDA: begin
            case (opc)
               `DBCD_OP_STATUS:  begin dec_code = `DBCD_C_REQ_STATUS; dec_pair = `DBCD_P_ADDR; end
               `DBCD_OP_READ:    begin dec_code = `DBCD_C_BUF_READ; dec_pair = `DBCD_P_TX; end
               `DBCD_OP_LOGADDR: begin dec_code = `DBCD_C_REQ_LOG; dec_pair = `DBCD_P_ADDR; end
               default:          dec_code = `DBCD_C_NONE;
            endcase
         end
         `DBCD_SEC_CMDB: begin
            if (opc == `DBCD_OP_READ) begin
               dec_code = `DBCD_C_BUF_RDVFY;
               dec_pair = `DBCD_P_TX;
            end
         end
         `DBCD_SEC_CMDC: begin
            case (opc)
               `DBCD_OP_READ:    begin dec_code = `DBCD_C_UBUF_RDVFY; dec_pair = `DBCD_P_TX; end
               `DBCD_OP_LOGADDR: begin dec_code = `DBCD_C_REQ_PHYS; dec_pair = `DBCD_P_ADDR; end
               `DBCD_OP_FORMAT:  begin dec_code = `DBCD_C_FORMAT; dec_len = 3'h4; end
               `DBCD_OP_LOCK:    dec_code = `DBCD_C_LOCK;
               `DBCD_OP_UNLOCK:  dec_code = `DBCD_C_UNLOCK;
               default:          dec_code = `DBCD_C_NONE;
            endcase
         end
         default: dec_code = `DBCD_C_NONE;
      endcase
   end

   // Opcode-free secondaries, listen or talk
   reg [4:0] sec_code;
   reg [1:0] sec_need;
   always @* begin
      sec_code = `DBCD_C_NONE;
      sec_need = `DBCD_P_NONE;
      if (s_lsn) begin
         case (s_data[4:0])
            `DBCD_SEC_RXDATA:   begin sec_code = `DBCD_C_RX_DATA; sec_need = `DBCD_P_RX; end
            `DBCD_SEC_CLEAR:    sec_code = `DBCD_C_DEV_CLEAR;
            `DBCD_SEC_CRC:      sec_code = `DBCD_C_CRC_RX;
            `DBCD_SEC_LOOP:     sec_code = `DBCD_C_WR_LOOP;
            `DBCD_SEC_SELFTEST: sec_code = `DBCD_C_SELFTEST;
            default:            sec_code = `DBCD_C_NONE;
         endcase
      end else if (s_tlk) begin
         case (s_data[4:0])
            `DBCD_SEC_RXDATA:   begin sec_code = `DBCD_C_TX_DATA; sec_need = `DBCD_P_TX; end
            `DBCD_SEC_CMD8:     begin sec_code = `DBCD_C_TX_ADDR; sec_need = `DBCD_P_ADDR; end
            `DBCD_SEC_CLEAR:    sec_code = `DBCD_C_TX_JUMP;
            `DBCD_SEC_CRC:      sec_code = `DBCD_C_CRC_TX;
            `DBCD_SEC_LOOP:     sec_code = `DBCD_C_RD_LOOP;
            `DBCD_SEC_SELFTEST: sec_code = `DBCD_C_RD_SELF;
            default:            sec_code = `DBCD_C_NONE;
         endcase
      end
   end
   wire opc_sec = s_lsn & ((s_data[4:0] >= `DBCD_SEC_CMD8) & (s_data[4:0] <= `DBCD_SEC_CMDC));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always @(posedge clk_in) begin
      if (reset_in) begin
         dav_q            <= 1'b0;
         state            <= ST_POWER;
         sec              <= 5'h00;
         pidx             <= 3'h0;
         plen             <= 3'h0;
         pend_pair        <= `DBCD_P_NONE;
         pend_code        <= `DBCD_C_NONE;
         ppd_wait         <= 1'b0;
         ppd_cnt          <= 16'h0000;
         hi_byte          <= 8'h00;
         byte_accept_out  <= 1'b0;
         poll_enable_out  <= 1'b0;
         cmd_valid_out    <= 1'b0;
         cmd_code_out     <= `DBCD_C_NONE;
         long_op_ok_out   <= 1'b0;
         error_out        <= `DBCD_E_NONE;
         error_valid_out  <= 1'b0;
         unit_out         <= 8'h00;
         cylinder_out     <= 16'h0000;
         head_out         <= 8'h00;
         sector_out       <= 8'h00;
         sector_count_out <= 16'h0000;
         params_valid_out <= 1'b0;
      end else begin
         dav_q            <= s_dav;
         byte_accept_out  <= 1'b0;
         cmd_valid_out    <= 1'b0;
         error_valid_out  <= 1'b0;
         params_valid_out <= 1'b0;
         // Poll drops at once; count sets minimum busy
         if (ppd_wait) begin
            ppd_cnt <= ppd_cnt + 16'h0001;
            if (ppd_cnt >= PPD_CYC[15:0] - 16'h0001) ppd_wait <= 1'b0;
         end
         // Clears and identify skip the decode
         if (s_uclr | s_sclr | s_ident) begin
            cmd_valid_out  <= 1'b1;
            cmd_code_out   <= s_uclr ? `DBCD_C_UNIV_CLEAR :
                              (s_sclr ? `DBCD_C_SEL_CLEAR : `DBCD_C_IDENTIFY);
            long_op_ok_out <= 1'b0;
            pend_pair      <= `DBCD_P_NONE;
            if (state != ST_POWER) state <= ST_BUSY;
         end else begin
            case (state)
               ST_POWER: begin
                  if (selftest_ok_in & drive_ready_in) begin
                     poll_enable_out <= 1'b1;
                     state           <= ST_IDLE;
                  end
               end
               ST_IDLE: begin
                  // Secondaries wait for this state
                  if (dav_rise & ~(is_sec & ~(s_lsn | s_tlk))) begin
                     byte_accept_out <= 1'b1;
                     if (is_sec) begin
                        poll_enable_out <= 1'b0;
                        ppd_wait        <= 1'b1;
                        ppd_cnt         <= 16'h0000;
                        sec             <= s_data[4:0];
                        if (opc_sec) begin
                           state <= ST_OPC;
                        end else if (sec_code == `DBCD_C_NONE) begin
                           error_out       <= `DBCD_E_ILLEGAL;
                           error_valid_out <= 1'b1;
                           pend_pair       <= `DBCD_P_NONE;
                           state           <= ST_BUSY;
                        end else if (sec_need != pend_pair) begin
                           error_out       <= `DBCD_E_PROGRAM;
                           error_valid_out <= 1'b1;
                           pend_pair       <= `DBCD_P_NONE;
                           state           <= ST_BUSY;
                        end else begin
                           cmd_valid_out <= 1'b1;
                           cmd_code_out  <= sec_code;
                           // Pair second releases long op
                           long_op_ok_out <= (sec_need != `DBCD_P_NONE);
                           pend_pair <= `DBCD_P_NONE;
                           state     <= ST_BUSY;
                        end
                     end
                  end
               end
               ST_OPC: begin
                  if (dav_rise & s_atn) begin
                     byte_accept_out <= 1'b1;
                     pend_pair       <= `DBCD_P_NONE;
                     state           <= ST_BUSY; // Aborted
                  end else if (dav_rise) begin
                     byte_accept_out <= 1'b1;
                     if (dec_code == `DBCD_C_NONE) begin
                        // Covers legacy opcodes and any unlisted pair
                        error_out       <= `DBCD_E_ILLEGAL;
                        error_valid_out <= 1'b1;
                        pend_pair       <= `DBCD_P_NONE;
                        state           <= ST_BUSY;
                     end else begin
                        if (pend_pair != `DBCD_P_NONE) begin
                           error_out       <= `DBCD_E_PROGRAM;
                           error_valid_out <= 1'b1;
                        end
                        pend_code <= dec_code;
                        pend_pair <= dec_pair;
                        plen      <= dec_len;
                        pidx      <= 3'h0;
                        state     <= ST_PARAM;
                     end
                  end
               end
               ST_PARAM: begin
                  if (dav_rise) begin
                     byte_accept_out <= 1'b1;
                     if (s_atn) begin
                        pend_pair <= `DBCD_P_NONE;
                        state     <= ST_BUSY;
                     end else begin
                        case (pidx)
                           3'h0: unit_out <= s_data;
                           3'h1: hi_byte  <= s_data;
                           3'h2: begin
                              cylinder_out     <= {hi_byte, s_data};
                              sector_count_out <= {hi_byte, s_data};
                           end
                           3'h3: head_out   <= s_data;
                           3'h4: sector_out <= s_data;
                           default: hi_byte <= hi_byte;
                        endcase
                        pidx <= pidx + 3'h1;
                        if (pidx + 3'h1 == plen) begin
                           params_valid_out <= 1'b1;
                           cmd_valid_out    <= 1'b1;
                           cmd_code_out     <= pend_code;
                           // Pair first waits
                           long_op_ok_out   <= (pend_pair == `DBCD_P_NONE);
                           state            <= (pend_pair == `DBCD_P_NONE) ? ST_BUSY : ST_IDLE;
                        end
                     end
                  end
               end
               ST_BUSY: begin
                  if (cmd_done_in & ~ppd_wait) begin
                     dav_q           <= 1'b0;
                     long_op_ok_out  <= 1'b0;
                     poll_enable_out <= 1'b1;
                     state           <= ST_IDLE;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // dbcd_decoder
`default_nettype wire

/* rtl/dbcd_regs.vh */
// Constants for the disc bus command decoder
`ifndef DBCD_REGS_VH
`define DBCD_REGS_VH
// Listen secondaries
`define DBCD_SEC_RXDATA   5'h00
`define DBCD_SEC_CMD8     5'h08
`define DBCD_SEC_CMD9     5'h09
`define DBCD_SEC_CMDA     5'h0a
`define DBCD_SEC_CMDB     5'h0b
`define DBCD_SEC_CMDC     5'h0c
`define DBCD_SEC_CLEAR    5'h10
`define DBCD_SEC_CRC      5'h11
`define DBCD_SEC_LOOP     5'h1e
`define DBCD_SEC_SELFTEST 5'h1f
// Opcodes (lower five bits)
`define DBCD_OP_SEEK      5'h02
`define DBCD_OP_STATUS    5'h03
`define DBCD_OP_READ      5'h05
`define DBCD_OP_VERIFY    5'h07
`define DBCD_OP_WRITE     5'h08
`define DBCD_OP_INIT      5'h0b
`define DBCD_OP_SETADDR   5'h0c
`define DBCD_OP_LOGADDR   5'h14
`define DBCD_OP_END       5'h15
`define DBCD_OP_FORMAT    5'h18
`define DBCD_OP_LOCK      5'h19
`define DBCD_OP_UNLOCK    5'h1a
// Command codes on cmd_code_out
`define DBCD_C_NONE       5'h00
`define DBCD_C_SEEK       5'h01
`define DBCD_C_REQ_STATUS 5'h02
`define DBCD_C_UBUF_READ  5'h03
`define DBCD_C_VERIFY     5'h04
`define DBCD_C_UBUF_WRITE 5'h05
`define DBCD_C_INIT       5'h06
`define DBCD_C_SET_ADDR   5'h07
`define DBCD_C_REQ_LOG    5'h08
`define DBCD_C_END        5'h09
`define DBCD_C_BUF_WRITE  5'h0a
`define DBCD_C_BUF_READ   5'h0b
`define DBCD_C_BUF_RDVFY  5'h0c
`define DBCD_C_UBUF_RDVFY 5'h0d
`define DBCD_C_REQ_PHYS   5'h0e
`define DBCD_C_FORMAT     5'h0f
`define DBCD_C_LOCK       5'h10
`define DBCD_C_UNLOCK     5'h11
`define DBCD_C_RX_DATA    5'h12
`define DBCD_C_DEV_CLEAR  5'h13
`define DBCD_C_CRC_RX     5'h14
`define DBCD_C_WR_LOOP    5'h15
`define DBCD_C_SELFTEST   5'h16
`define DBCD_C_TX_DATA    5'h17
`define DBCD_C_TX_ADDR    5'h18
`define DBCD_C_TX_JUMP    5'h19
`define DBCD_C_CRC_TX     5'h1a
`define DBCD_C_RD_LOOP    5'h1b
`define DBCD_C_RD_SELF    5'h1c
`define DBCD_C_UNIV_CLEAR 5'h1d
`define DBCD_C_SEL_CLEAR  5'h1e
`define DBCD_C_IDENTIFY   5'h1f
// Pair classes
`define DBCD_P_NONE       2'h0
`define DBCD_P_ADDR       2'h1
`define DBCD_P_TX         2'h2
`define DBCD_P_RX         2'h3
// Error codes
`define DBCD_E_NONE       2'h0
`define DBCD_E_PROGRAM    2'h1
`define DBCD_E_ILLEGAL    2'h2
// Poll withdraw time
`define DBCD_PPD_NS       50000
`define DBCD_CLK_NS       25
`endif

/* rtl/dbcd_sync.v */
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module dbcd_sync #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         reset_in,
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);
   reg [W-1:0] meta;
   // First stage is read only by the second
   always @(posedge clk_in) begin
      if (reset_in) begin
         meta  <= {W{1'b0}};
         q_out <= {W{1'b0}};
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule // dbcd_sync
`default_nettype wire

/* test/dbcd_monitor.sv */
// Port-level checker for the command decoder
`default_nettype none
`include "dbcd_regs.vh"
module dbcd_monitor (
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic        bus_dav_in,
   input wire logic        selftest_ok_in,
   input wire logic        drive_ready_in,
   input wire logic        byte_accept_out,
   input wire logic        poll_enable_out,
   input wire logic        cmd_valid_out,
   input wire logic [4:0]  cmd_code_out,
   input wire logic        long_op_ok_out,
   input wire logic [1:0]  error_out,
   input wire logic        error_valid_out,
   input wire logic        params_valid_out
);
   logic [11:0] low_cnt;
   logic        seen;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   ////////////////////////////////////////////////////////////////////////////
   // Poll-low cycles, saturating
   always @(posedge clk_in) begin
      if (reset_in || poll_enable_out) begin
         low_cnt <= 12'h000;
         seen    <= 1'b0;
      end else begin
         if (low_cnt != 12'hfff) low_cnt <= low_cnt + 12'h001;
         if (byte_accept_out) seen <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_poll_needs_ready: assert property ($rose(poll_enable_out) |->
      $past(selftest_ok_in) && $past(drive_ready_in)) else $error("poll rose before ready");
   a_cmd_poll_off: assert property (cmd_valid_out && cmd_code_out < `DBCD_C_UNIV_CLEAR
      |-> !poll_enable_out) else $error("poll still on with command");
   a_busy_min_time: assert property ($rose(poll_enable_out) && seen
      |-> low_cnt >= 12'h7c6) else $error("poll back too soon");
   a_pair_no_long: assert property (cmd_valid_out && cmd_code_out inside {
      `DBCD_C_REQ_STATUS, `DBCD_C_REQ_LOG, `DBCD_C_REQ_PHYS, `DBCD_C_BUF_READ,
      `DBCD_C_UBUF_READ, `DBCD_C_BUF_RDVFY, `DBCD_C_UBUF_RDVFY, `DBCD_C_BUF_WRITE,
      `DBCD_C_UBUF_WRITE, `DBCD_C_INIT} |-> !long_op_ok_out) else $error("long op on pair");
   a_seek_long_ok: assert property (cmd_valid_out && cmd_code_out == `DBCD_C_SEEK
      |-> long_op_ok_out) else $error("seek without long op");
   a_accept_lag: assert property (byte_accept_out |-> $past(bus_dav_in, 2))
      else $error("accept without valid byte");
   a_params_with_cmd: assert property (params_valid_out |-> cmd_valid_out)
      else $error("params without command");
   a_err_code_legal: assert property (error_valid_out |->
      error_out inside {`DBCD_E_PROGRAM, `DBCD_E_ILLEGAL}) else $error("bad error code");
   a_err_no_cmd: assert property (error_valid_out |-> !cmd_valid_out)
      else $error("command issued with error");
   a_cmd_on_accept: assert property (cmd_valid_out && cmd_code_out < `DBCD_C_UNIV_CLEAR
      |-> byte_accept_out) else $error("command without byte");
endmodule // dbcd_monitor
`default_nettype wire

/* test/dbcd_host.sv */
// Host bus controller model driving command bytes
`default_nettype none
module dbcd_host (
   input  wire logic       clk_in,
   input  wire logic       accept_in,
   output var  logic [7:0] data_out,
   output var  logic       atn_out,
   output var  logic       dav_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      data_out = 8'h00;
      atn_out  = 1'b0;
      dav_out  = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Present a byte until taken
   task put(input logic [7:0] b, input logic a);
      @(posedge clk_in);
      data_out <= b;
      atn_out  <= a;
      dav_out  <= 1'b1;
   endtask
   // Wait for accept; released data inverts
   task take(input int bound, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < bound && !ok; i++) begin
         @(posedge clk_in);
         ok = (accept_in === 1'b1);
      end
      if (ok) begin
         dav_out  <= 1'b0;
         atn_out  <= 1'b0;
         data_out <= ~data_out;
         repeat (3) @(posedge clk_in);
      end
   endtask
endmodule // dbcd_host
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the command decoder
`default_nettype none
`include "dbcd_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, reset_in = 1, listen_in = 1, talk_in = 0, univ_clear_in = 0;
   logic sel_clear_in = 0, identify_in = 0, selftest_ok_in = 1, drive_ready_in = 1;
   logic cmd_done_in = 0, bus_atn_in, bus_dav_in, byte_accept_out, poll_enable_out;
   logic cmd_valid_out, long_op_ok_out, error_valid_out, params_valid_out, got_long, ok;
   logic [7:0]  bus_data_in, unit_out, head_out, sector_out;
   logic [4:0]  cmd_code_out, got_code;
   logic [1:0]  error_out, got_err;
   logic [15:0] cylinder_out, sector_count_out;
   int fails = 0, n_tests = 0, nacc = 0, k;
   always #12.5 clk_in = ~clk_in;
   dbcd_host host (.clk_in(clk_in), .accept_in(byte_accept_out), .data_out(bus_data_in),
      .atn_out(bus_atn_in), .dav_out(bus_dav_in));
   dbcd_decoder DUT (.clk_in(clk_in), .reset_in(reset_in), .bus_data_in(bus_data_in),
      .bus_atn_in(bus_atn_in), .bus_dav_in(bus_dav_in), .listen_in(listen_in),
      .talk_in(talk_in), .univ_clear_in(univ_clear_in), .sel_clear_in(sel_clear_in),
      .identify_in(identify_in), .selftest_ok_in(selftest_ok_in),
      .drive_ready_in(drive_ready_in), .cmd_done_in(cmd_done_in),
      .byte_accept_out(byte_accept_out), .poll_enable_out(poll_enable_out),
      .cmd_valid_out(cmd_valid_out), .cmd_code_out(cmd_code_out),
      .long_op_ok_out(long_op_ok_out), .error_out(error_out),
      .error_valid_out(error_valid_out), .unit_out(unit_out), .cylinder_out(cylinder_out),
      .head_out(head_out), .sector_out(sector_out), .sector_count_out(sector_count_out),
      .params_valid_out(params_valid_out));
   ////////////////////////////////////////////////////////////////////////////
   // Latch one-cycle results
   always @(posedge clk_in) begin
      if (reset_in) begin
         got_code <= `DBCD_C_NONE;
         got_long <= 1'b0;
         got_err  <= `DBCD_E_NONE;
      end else begin
         if (cmd_valid_out === 1'b1) begin
            got_code <= cmd_code_out;
            got_long <= long_op_ok_out;
         end
         if (error_valid_out === 1'b1) got_err <= error_out;
         if (byte_accept_out === 1'b1) nacc <= nacc + 1;
      end
   end
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Bound ran out
   task give_up;
      fails++;
      results;
   endtask
   task xfer(input logic [7:0] b, input logic a);
      host.put(b, a);
      host.take(3000, ok);
      if (!ok) give_up;
   endtask
   task rst(input logic t);
      @(posedge clk_in);
      reset_in <= 1'b1;
      listen_in <= !t;
      talk_in <= t;
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
   endtask
   // Secondary, opcode unless op[5], n zero bytes
   task one(input logic t, input logic [4:0] s, input logic [5:0] op, input int n,
            input logic [4:0] code);
      rst(t);
      xfer({3'h3, s}, 1'b1);
      if (!op[5]) xfer({3'h0, op[4:0]}, 1'b0);
      repeat (n) xfer(8'h00, 1'b0);
      @(posedge clk_in);
      chk(16'(got_code), 16'(code));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_power;
      {selftest_ok_in, drive_ready_in} <= 2'h0;
      rst(1'b0);
      repeat (20) @(posedge clk_in);
      chk(16'(poll_enable_out), 16'h0000);
      {selftest_ok_in, drive_ready_in} <= 2'h3;
      repeat (3) @(posedge clk_in);
      chk(16'(poll_enable_out), 16'h0001);
   endtask
   task t_seek;
      rst(1'b0);
      xfer(8'h68, 1'b1);
      @(posedge clk_in);
      chk(16'(poll_enable_out), 16'h0000);
      xfer(8'he2, 1'b0);
      xfer(8'h03, 1'b0);
      xfer(8'h12, 1'b0);
      xfer(8'h34, 1'b0);
      xfer(8'h01, 1'b0);
      xfer(8'h05, 1'b0);
      @(posedge clk_in);
      chk(16'(got_code), 16'(`DBCD_C_SEEK));
      chk(16'(got_long), 16'h0001);
      chk(cylinder_out, 16'h1234);
      chk({unit_out, head_out}, 16'h0301);
      chk(16'(sector_out), 16'h0005);
      k = nacc;
      host.put(8'h68, 1'b1);
      repeat (2100) @(posedge clk_in);
      chk(16'(nacc - k), 16'h0000);
      cmd_done_in <= 1'b1;
      host.take(3000, ok);
      chk(16'(ok), 16'h0001);
      cmd_done_in <= 1'b0;
   endtask
   task t_verify;
      one(1'b0, 5'h08, 6'h07, 3, `DBCD_C_VERIFY);
      chk(sector_count_out, 16'h0000);
      rst(1'b0);
      xfer(8'h68, 1'b1);
      xfer(8'h07, 1'b0);
      xfer(8'h01, 1'b0);
      xfer(8'hab, 1'b0);
      xfer(8'hcd, 1'b0);
      @(posedge clk_in);
      chk(sector_count_out, 16'habcd);
   endtask
   task t_pair;
      one(1'b0, 5'h08, 6'h05, 1, `DBCD_C_UBUF_READ);
      chk(16'(got_long), 16'h0000);
      listen_in <= 1'b0;
      talk_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      xfer(8'h60, 1'b1);
      @(posedge clk_in);
      chk(16'(got_code), 16'(`DBCD_C_TX_DATA));
      chk(16'(got_long), 16'h0001);
      one(1'b1, 5'h00, 6'h20, 0, `DBCD_C_NONE);
      chk(16'(got_err), 16'(`DBCD_E_PROGRAM));
      one(1'b0, 5'h0a, 6'h05, 1, `DBCD_C_BUF_READ);
      xfer(8'h68, 1'b1);
      xfer(8'h03, 1'b0);
      @(posedge clk_in);
      chk(16'(got_err), 16'(`DBCD_E_PROGRAM));
   endtask
   task t_table;
      one(0, 5'h08, 6'h03, 1, `DBCD_C_REQ_STATUS);
      one(0, 5'h08, 6'h08, 1, `DBCD_C_UBUF_WRITE);
      one(0, 5'h08, 6'h0b, 1, `DBCD_C_INIT);
      one(0, 5'h08, 6'h0c, 5, `DBCD_C_SET_ADDR);
      one(0, 5'h08, 6'h14, 1, `DBCD_C_REQ_LOG);
      one(0, 5'h08, 6'h15, 1, `DBCD_C_END);
      one(0, 5'h09, 6'h08, 1, `DBCD_C_BUF_WRITE);
      one(0, 5'h0a, 6'h03, 1, `DBCD_C_REQ_STATUS);
      one(0, 5'h0a, 6'h14, 1, `DBCD_C_REQ_LOG);
      one(0, 5'h0b, 6'h05, 1, `DBCD_C_BUF_RDVFY);
      one(0, 5'h0c, 6'h05, 1, `DBCD_C_UBUF_RDVFY);
      one(0, 5'h0c, 6'h14, 1, `DBCD_C_REQ_PHYS);
      one(0, 5'h0c, 6'h18, 4, `DBCD_C_FORMAT);
      one(0, 5'h0c, 6'h19, 1, `DBCD_C_LOCK);
      one(0, 5'h0c, 6'h1a, 1, `DBCD_C_UNLOCK);
      one(0, 5'h10, 6'h20, 0, `DBCD_C_DEV_CLEAR);
      one(0, 5'h11, 6'h20, 0, `DBCD_C_CRC_RX);
      one(0, 5'h1e, 6'h20, 0, `DBCD_C_WR_LOOP);
      one(0, 5'h1f, 6'h20, 0, `DBCD_C_SELFTEST);
      one(1, 5'h10, 6'h20, 0, `DBCD_C_TX_JUMP);
      one(1, 5'h11, 6'h20, 0, `DBCD_C_CRC_TX);
      one(1, 5'h1e, 6'h20, 0, `DBCD_C_RD_LOOP);
      one(1, 5'h1f, 6'h20, 0, `DBCD_C_RD_SELF);
      one(0, 5'h0c, 6'h1b, 0, `DBCD_C_NONE);
      chk(16'(got_err), 16'(`DBCD_E_ILLEGAL));
      one(0, 5'h0d, 6'h20, 0, `DBCD_C_NONE);
      chk(16'(got_err), 16'(`DBCD_E_ILLEGAL));
   endtask
   // One-cycle clear and identify pins
   task t_clear;
      for (int i = 0; i < 3; i++) begin
         rst(1'b0);
         {univ_clear_in, sel_clear_in, identify_in} <= 3'h4 >> i;
         @(posedge clk_in);
         {univ_clear_in, sel_clear_in, identify_in} <= 3'h0;
         repeat (6) @(posedge clk_in);
         chk(16'(got_code), 16'(`DBCD_C_UNIV_CLEAR + i));
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      t_power;
      $display("power done");
      t_seek;
      $display("seek done");
      t_verify;
      $display("verify done");
      t_pair;
      $display("pair done");
      t_table;
      $display("table done");
      t_clear;
      $display("clear done");
      results;
   end
endmodule // testbench
bind dbcd_decoder dbcd_monitor mon (.clk_in(clk_in), .reset_in(reset_in),
   .bus_dav_in(bus_dav_in), .selftest_ok_in(selftest_ok_in),
   .drive_ready_in(drive_ready_in), .byte_accept_out(byte_accept_out),
   .poll_enable_out(poll_enable_out), .cmd_valid_out(cmd_valid_out),
   .cmd_code_out(cmd_code_out), .long_op_ok_out(long_op_ok_out), .error_out(error_out),
   .error_valid_out(error_valid_out), .params_valid_out(params_valid_out));
`default_nettype wire
